// File: hw/cfd_pkg.sv
// Purpose: constants and types for the capability format decoder
// Assumes: widest_int_width is 32 or 64; the rest derives from it
// Notes: field positions give the packed layout of one capability word
package cfd_pkg;
  // ----------------------------------------------------------------
  // capability geometry
  // ----------------------------------------------------------------
  localparam int widest_int_width = 64;
  localparam int capability_width = 2 * widest_int_width;
  localparam bit extra_top_en = (widest_int_width == 32);
  localparam int mantissa_width = extra_top_en ? 10 : 14;
  localparam int exponent_width = extra_top_en ? 5 : 6;
  localparam int max_exponent = widest_int_width - mantissa_width + 2;
  localparam int half_exp = exponent_width / 2;
  localparam int arch_w = extra_top_en ? 4 : 5;
  localparam int soft_w = extra_top_en ? 2 : 4;
  // ----------------------------------------------------------------
  // field positions, metadata in the upper half
  // ----------------------------------------------------------------
  localparam int base_lsb = widest_int_width;
  localparam int top_lsb = base_lsb + mantissa_width;
  localparam int extra_top_pos = top_lsb + mantissa_width - 2;
  localparam int form_pos = extra_top_pos + (extra_top_en ? 1 : 0);
  localparam int seal_pos = form_pos + 1;
  localparam int arch_lsb = seal_pos + 1;
  localparam int res_lsb = arch_lsb + arch_w;
  localparam int soft_lsb = capability_width - soft_w;
  localparam int res_w = soft_lsb - res_lsb;
  localparam logic [capability_width-1:0] reserved_mask =
    {{soft_w{1'b0}}, {res_w{1'b1}}, {res_lsb{1'b0}}};
  localparam logic [4:0] arch_code_reserved = 5'h01;
  // ----------------------------------------------------------------
  // register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] off_ctrl = 8'h00;
  localparam logic [7:0] off_status = 8'h04;
  localparam logic [7:0] off_cap0 = 8'h10;
  localparam logic [7:0] off_chk0 = 8'h20;
  localparam logic [7:0] off_base0 = 8'h30;
  localparam logic [7:0] off_top0 = 8'h38;
  localparam logic [7:0] off_top_ext = 8'h40;
  localparam int cap_words = capability_width / 32;
  localparam int int_words = widest_int_width / 32;
  localparam int ctrl_cmd_lsb = 0;
  localparam int ctrl_kind_lsb = 4;
  localparam int ctrl_soft_lsb = 8;
  localparam logic [2:0] kind_reset = 3'h0;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // ----------------------------------------------------------------
  // commands, access kinds, right bits
  // ----------------------------------------------------------------
  localparam logic [2:0] cmd_jump = 3'h1;
  localparam logic [2:0] cmd_link_seal = 3'h2;
  localparam logic [2:0] cmd_set_soft = 3'h3;
  localparam logic [2:0] kind_read = 3'h0;
  localparam logic [2:0] kind_write = 3'h1;
  localparam logic [2:0] kind_exec = 3'h2;
  localparam logic [2:0] kind_load_cap = 3'h3;
  localparam logic [2:0] kind_store_cap = 3'h4;
  localparam int right_c = 0;
  localparam int right_w = 1;
  localparam int right_r = 2;
  localparam int right_x = 3;
  localparam int right_sys = 4;

  typedef struct packed {
    logic [4:0] rights;
    logic [widest_int_width-1:0] base;
    logic [widest_int_width:0] top;
    logic signed [7:0] exponent;
    logic exponent_form_flag;
    logic sealed;
    logic malformed;
    logic res_bad;
    logic arch_bad;
  } cfd_dec_t;
endpackage : cfd_pkg

// File: hw/cfd_top.sv
// Purpose: capability decoder with held capability, checker and register slave
// Assumes: core-side ports are on aclk; axi4-lite master of 32-bit data
// Notes: decode is combinational on the held word; writes act one edge later
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module cfd_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core capability load and integer store
  input wire logic cap_load_valid,
  input wire logic [cfd_pkg::capability_width-1:0] cap_load_data,
  input wire logic cap_load_tag,
  input wire logic int_store,
  // core access check
  input wire logic core_req,
  input wire logic [cfd_pkg::widest_int_width-1:0] core_addr,
  input wire logic [2:0] core_kind,
  output logic core_grant,
  output logic core_fault,
  // decoded view of the held capability
  output logic cap_valid,
  output logic [4:0] rights,
  output logic [cfd_pkg::widest_int_width-1:0] base,
  output logic [cfd_pkg::widest_int_width:0] top,
  // jump target into the pcc
  output logic jump_valid,
  output logic [cfd_pkg::capability_width-1:0] jump_cap,
  output logic jump_tag
);
  import cfd_pkg::*;

  localparam int xw = widest_int_width;
  localparam int mw = mantissa_width;

  typedef struct packed {
    logic [capability_width-1:0] cap;
    logic tag;
    logic [xw-1:0] chk_addr;
    logic [2:0] kind;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic jump_valid;
    logic [capability_width-1:0] jump_cap;
    logic jump_tag;
  } cfd_state_t;

  cfd_state_t st;
  cfd_state_t next_st;
  cfd_dec_t cur;
  cfd_dec_t ld;
  logic ld_ok;
  logic chk_ok;
  logic wr_do;

  // ----------------------------------------------------------------
  // bounds and rights decode
  // ----------------------------------------------------------------
  function automatic logic [xw+1:0] corr(input logic a_lo, input logic f_lo);
    if (a_lo == f_lo)
      return '0;
    return f_lo ? (xw+2)'(1) : '1;
  endfunction : corr

  function automatic cfd_dec_t cfd_decode(input logic [capability_width-1:0] c);
    cfd_dec_t d;
    logic [mw-1:0] bm;
    logic [mw-3:0] tlow;
    logic [mw-1:0] tm;
    logic [1:0] top2;
    logic [exponent_width-1:0] ecode;
    logic [6:0] e_u;
    logic [7:0] sh;
    logic extra_top_bit;
    logic length_carry;
    logic length_high_bit;
    logic [2:0] ac;
    logic [2:0] rr;
    logic [xw+1:0] aw;
    logic [xw+1:0] ahi;
    logic [xw+1:0] tt;
    logic [xw+1:0] bb;
    logic [4:0] arch_code;
    logic signed [2:0] wrap;
    d = '0;
    aw = (xw+2)'(c[xw-1:0]);
    bm = c[base_lsb +: mw];
    tlow = c[top_lsb +: mw-2];
    extra_top_bit = extra_top_en ? c[extra_top_pos] : 1'b0;
    d.exponent_form_flag = c[form_pos];
    d.sealed = c[seal_pos];
    ecode = exponent_width'({tlow[half_exp-1:0], bm[half_exp-1:0]})
      | (exponent_width'(extra_top_bit) << (exponent_width-1));
    if (d.exponent_form_flag)
    begin
      d.exponent = 8'sd0;
      length_high_bit = extra_top_bit;
    end
    else
    begin
      d.exponent = 8'(max_exponent) - 8'(ecode);
      length_high_bit = 1'b1;
      bm[half_exp-1:0] = '0;
      tlow[half_exp-1:0] = '0;
    end
    length_carry = (tlow < bm[mw-3:0]);
    top2 = bm[mw-1:mw-2] + 2'(length_carry) + 2'(length_high_bit);
    tm = {top2, tlow};
    e_u = d.exponent[7] ? 7'd0 : d.exponent[6:0];
    sh = 8'(e_u) + 8'(mw);
    ahi = aw >> sh;
    ac = 3'(aw >> (sh - 8'd3));
    rr = bm[mw-1:mw-3] - 3'd1;
    tt = ((ahi + corr(ac < rr, tm[mw-1:mw-3] < rr)) << sh) | ((xw+2)'(tm) << e_u);
    bb = ((ahi + corr(ac < rr, bm[mw-1:mw-3] < rr)) << sh) | ((xw+2)'(bm) << e_u);
    d.base = bb[xw-1:0];
    d.top = tt[xw:0];
    wrap = $signed({1'b0, d.top[xw:xw-1]}) - $signed({2'b00, d.base[xw-1]});
    if ((d.exponent < $signed(8'(max_exponent - 1))) && (wrap > 3'sd1))
      d.top[xw] = ~d.top[xw];
    d.malformed = !d.exponent_form_flag && (d.exponent[7]
      || (d.exponent == $signed(8'(max_exponent)) && bm[mw-1:mw-2] != 2'b00)
      || (d.exponent == $signed(8'(max_exponent - 1)) && bm[mw-1]));
    arch_code = 5'(c[arch_lsb +: arch_w]);
    if (extra_top_en)
    begin
      d.rights[right_c] = arch_code[0];
      d.rights[right_w] = arch_code[1];
      d.rights[right_x] = arch_code[3];
      d.rights[right_r] = arch_code[3] | arch_code[2];
      d.rights[right_sys] = arch_code[3] & arch_code[2];
      d.arch_bad = (arch_code == arch_code_reserved);
    end
    else
      d.rights = arch_code;
    d.res_bad = |(c & reserved_mask);
    return d;
  endfunction : cfd_decode

  function automatic logic access_ok(input cfd_dec_t d, input logic valid,
                                     input logic [xw-1:0] addr, input logic [2:0] kind);
    logic need;
    case (kind)
      kind_read: need = d.rights[right_r];
      kind_write: need = d.rights[right_w];
      kind_exec: need = d.rights[right_x];
      kind_load_cap: need = d.rights[right_c] & d.rights[right_r];
      kind_store_cap: need = d.rights[right_c] & d.rights[right_w];
      default: need = 1'b0;
    endcase
    return valid && !d.sealed && need
      && ({1'b0, addr} >= {1'b0, d.base}) && ({1'b0, addr} < d.top);
  endfunction : access_ok

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : merge

  // soft_rights_bits are carried only, never decoded
  always_comb cur = cfd_decode(st.cap);
  always_comb ld = cfd_decode(cap_load_data);
  assign cap_valid = st.tag && !cur.malformed && !cur.res_bad && !cur.arch_bad;
  assign ld_ok = cap_load_tag && !ld.malformed && !ld.res_bad && !ld.arch_bad;
  assign rights = cur.rights;
  assign base = cur.base;
  assign top = cur.top;
  assign chk_ok = access_ok(cur, cap_valid, st.chk_addr, st.kind);
  assign core_grant = core_req && access_ok(cur, cap_valid, core_addr, core_kind);
  assign core_fault = core_req && !core_grant;

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !st.aw_got && !st.bvalid;
  assign s_axi_wready = !st.w_got && !st.bvalid;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign jump_valid = st.jump_valid;
  assign jump_cap = st.jump_cap;
  assign jump_tag = st.jump_tag;
  assign wr_do = st.aw_got && st.w_got && !st.bvalid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic hit;
    logic [7:0] wa;
    logic [7:0] ra;
    logic [31:0] sts;
    logic [xw+63:0] topx;
    hit = 1'b0;
    sts = '0;
    wa = {st.awaddr[7:2], 2'b00};
    ra = {s_axi_araddr[7:2], 2'b00};
    topx = (xw+64)'(cur.top);
    next_st = st;
    next_st.jump_valid = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;
    if (wr_do)
    begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      if (wa == off_ctrl)
      begin
        hit = 1'b1;
        if (st.wstrb[0])
          next_st.kind = st.wdata[ctrl_kind_lsb +: 3];
        if (st.wstrb[0] && st.wdata[ctrl_cmd_lsb +: 3] == cmd_jump)
        begin
          next_st.jump_valid = 1'b1;
          next_st.jump_cap = st.cap;
          next_st.jump_cap[seal_pos] = 1'b0;
          next_st.jump_tag = cap_valid;
        end
        if (st.wstrb[0] && st.wdata[ctrl_cmd_lsb +: 3] == cmd_link_seal)
        begin
          next_st.cap[seal_pos] = 1'b1;
          next_st.tag = cap_valid;
        end
        if (st.wstrb[0] && st.wdata[ctrl_cmd_lsb +: 3] == cmd_set_soft)
        begin
          next_st.cap[soft_lsb +: soft_w] = st.wdata[ctrl_soft_lsb +: soft_w];
          next_st.tag = cap_valid && !cur.sealed;
        end
      end
      for (int k = 0; k < cap_words; k++)
        if (wa == off_cap0 + 8'(4*k))
        begin
          hit = 1'b1;
          next_st.cap[32*k +: 32] = merge(st.cap[32*k +: 32], st.wdata, st.wstrb);
          next_st.tag = 1'b0;
        end
      for (int k = 0; k < int_words; k++)
        if (wa == off_chk0 + 8'(4*k))
        begin
          hit = 1'b1;
          next_st.chk_addr[32*k +: 32] = merge(st.chk_addr[32*k +: 32], st.wdata, st.wstrb);
        end
      if (wa == off_status)
        hit = 1'b1;
      next_st.bresp = hit ? resp_okay : resp_slverr;
    end
    // status word, assembled for reads
    sts[0] = st.tag;
    sts[1] = cap_valid;
    sts[2] = cur.sealed;
    sts[3] = cur.malformed;
    sts[4] = cur.res_bad | cur.arch_bad;
    sts[5] = cur.exponent_form_flag;
    sts[12:8] = cur.rights;
    sts[16] = chk_ok;
    sts[31:24] = cur.exponent;
    if (s_axi_rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata = '0;
      next_st.rresp = resp_okay;
      if (ra == off_ctrl)
        next_st.rdata[ctrl_kind_lsb +: 3] = st.kind;
      else if (ra == off_status)
        next_st.rdata = sts;
      else if (ra == off_top_ext)
        next_st.rdata[0] = cur.top[xw];
      else
        next_st.rresp = resp_slverr;
      for (int k = 0; k < cap_words; k++)
        if (ra == off_cap0 + 8'(4*k))
        begin
          next_st.rdata = st.cap[32*k +: 32];
          next_st.rresp = resp_okay;
        end
      for (int k = 0; k < int_words; k++)
      begin
        if (ra == off_chk0 + 8'(4*k))
        begin
          next_st.rdata = st.chk_addr[32*k +: 32];
          next_st.rresp = resp_okay;
        end
        if (ra == off_base0 + 8'(4*k))
        begin
          next_st.rdata = cur.base[32*k +: 32];
          next_st.rresp = resp_okay;
        end
        if (ra == off_top0 + 8'(4*k))
        begin
          next_st.rdata = topx[32*k +: 32];
          next_st.rresp = resp_okay;
        end
      end
    end
    // core side: an integer store clears, a capability load (later) wins
    if (int_store)
      next_st.tag = 1'b0;
    if (cap_load_valid)
    begin
      next_st.cap = cap_load_data;
      next_st.tag = ld_ok;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st <= '0;
      st.kind <= kind_reset;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_untagged_denies;
    !st.tag |-> !core_grant && (core_req == core_fault);
  endproperty
  a_untagged_denies: assert property (p_untagged_denies) else $error("untagged capability granted");

  property p_int_store_clears;
    int_store && !cap_load_valid |=> !st.tag && !cap_valid;
  endproperty
  a_int_store_clears: assert property (p_int_store_clears) else $error("integer store left tag");

  logic wa_is_cap;
  assign wa_is_cap = (st.awaddr >= off_cap0) && (st.awaddr < off_cap0 + 8'(4*cap_words));
  property p_cap_word_write_clears;
    wr_do && wa_is_cap && !cap_load_valid |=> !st.tag ##1 (!st.tag || $past(cap_load_valid));
  endproperty
  a_cap_word_write_clears: assert property (p_cap_word_write_clears) else $error("tag survived bus write");

  property p_load_cap_rights;
    core_grant && core_kind == kind_load_cap |-> rights[right_c] && rights[right_r];
  endproperty
  a_load_cap_rights: assert property (p_load_cap_rights) else $error("load without rights");

  property p_sealed_denies;
    cur.sealed |-> !core_grant;
  endproperty
  a_sealed_denies: assert property (p_sealed_denies) else $error("sealed capability granted");

  property p_in_bounds;
    core_grant |-> ({1'b0, core_addr} >= {1'b0, base}) && ({1'b0, core_addr} < top);
  endproperty
  a_in_bounds: assert property (p_in_bounds) else $error("grant outside bounds");

  property p_malformed_untagged;
    cap_load_valid && ld.malformed |=> !st.tag;
  endproperty
  a_malformed_untagged: assert property (p_malformed_untagged) else $error("malformed kept tag");

  property p_reserved_clear;
    cap_valid |-> (st.cap & reserved_mask) == '0;
  endproperty
  a_reserved_clear: assert property (p_reserved_clear) else $error("reserved bits in valid cap");

  property p_jump_unseals;
    wr_do && st.awaddr == off_ctrl && st.wstrb[0] && st.wdata[2:0] == cmd_jump
      |=> jump_valid && !jump_cap[seal_pos] && jump_tag == $past(cap_valid) ##1 !jump_valid;
  endproperty
  a_jump_unseals: assert property (p_jump_unseals) else $error("jump did not unseal");
endmodule : cfd_top

// File: bench/tb.sv
// Purpose: self-checking bench for the capability format decoder
// Assumes: 64-bit geometry from cfd_pkg; axi4-lite master, one transfer at a time
// Notes: core-side results are sampled at the edge after their inputs change
`timescale 1ns/1ps
module tb;
  import cfd_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic cap_load_valid = 1'b0, cap_load_tag = 1'b0, int_store = 1'b0, core_req = 1'b0;
  logic [capability_width-1:0] cap_load_data = 128'h0, jump_cap, jcap, w;
  logic [63:0] core_addr = 64'h0, base;
  logic [2:0] core_kind = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic core_grant, core_fault, cap_valid, jump_valid, jump_tag, jtag;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] rights;
  logic [64:0] top;
  int mismatches = 0, checks = 0, jumps = 0;
  cfd_top i_cfd_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cap_load_valid, .cap_load_data, .cap_load_tag, .int_store, .core_req, .core_addr,
    .core_kind, .core_grant, .core_fault, .cap_valid, .rights, .base, .top, .jump_valid, .jump_cap, .jump_tag);
  initial forever #12.5 aclk = ~aclk;
  // jump pulses are counted so a stretched pulse shows up as a second count
  always @(posedge aclk)
  begin
    if (jump_valid)
    begin
      jumps <= jumps + 1;
      jcap <= jump_cap;
      jtag <= jump_tag;
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_bvalid; n++)
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    check("bvalid", s_axi_bvalid, 1'b1);
    if (!s_axi_bvalid)
      report_and_stop();
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50 && !s_axi_rvalid; n++)
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    check("rvalid", s_axi_rvalid, 1'b1);
    if (!s_axi_rvalid)
      report_and_stop();
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read
  task automatic load_cap(input logic [127:0] c, input logic t);
    cap_load_data <= c;
    cap_load_tag <= t;
    cap_load_valid <= 1'b1;
    @(posedge aclk);
    cap_load_valid <= 1'b0;
    @(posedge aclk);
  endtask : load_cap
  task automatic access(input logic [63:0] a, input logic [2:0] k, input logic exp);
    core_req <= 1'b1;
    core_addr <= a;
    core_kind <= k;
    @(posedge aclk);
    check("core_grant", core_grant, exp);
    check("core_fault", core_fault, !exp);
  endtask : access
  // soft rights nibble is always 4'ha: hardware must ignore it
  function automatic logic [127:0] mk(input logic [63:0] a, input logic [13:0] b, input logic [11:0] t,
    input logic form, input logic s, input logic [4:0] code);
    return {4'ha, 27'h0, code, s, form, t, b, a};
  endfunction : mk
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("cap_valid", cap_valid, 1'b0);
    check("top", top, 65'h1_0000_0000_0000_0000);
    axi_read(off_status);
    check("status", rd, 32'h3400_0000);
    axi_read(8'h80);
    check("rresp", {rd, resp}, {32'h0, resp_slverr});
    axi_write(8'h90, 32'h1, 4'hf);
    check("bresp", resp, resp_slverr);
  endtask : t_reset
  task automatic t_bounds;
    w = mk(64'h100, 14'h0080, 12'h200, 1'b1, 1'b0, 5'h1f);
    load_cap(w, 1'b0);
    check("cap_valid", cap_valid, 1'b0);
    access(64'h100, kind_read, 1'b0);
    load_cap(w, 1'b1);
    check("base", base, 64'h80);
    check("top", top, 65'h200);
    access(64'h80, kind_read, 1'b1);
    access(64'h1ff, kind_write, 1'b1);
    access(64'h200, kind_read, 1'b0);
    access(64'h7f, kind_read, 1'b0);
    access(64'h100, 3'h5, 1'b0);
  endtask : t_bounds
  task automatic t_rights;
    logic [4:0] code;
    for (int i = 0; i < 32; i++)
    begin
      code = i[4:0];
      load_cap(mk(64'h100, 14'h0080, 12'h200, 1'b1, 1'b0, code), 1'b1);
      check("rights", rights, code);
      access(64'h100, kind_read, code[2]);
      access(64'h100, kind_write, code[1]);
      access(64'h100, kind_exec, code[3]);
      access(64'h100, kind_load_cap, code[0] & code[2]);
      access(64'h100, kind_store_cap, code[0] & code[1]);
    end
  endtask : t_rights
  task automatic t_tag_clear;
    w = mk(64'h1234_5678_9abc_def0, 14'h0080, 12'h200, 1'b1, 1'b0, 5'h1f);
    load_cap(w, 1'b1);
    check("cap_valid", cap_valid, 1'b1);
    int_store <= 1'b1;
    @(posedge aclk);
    int_store <= 1'b0;
    @(posedge aclk);
    check("cap_valid", cap_valid, 1'b0);
    load_cap(w, 1'b1);
    axi_read(off_cap0);
    check("cap word 0", rd, 32'h9abc_def0);
    axi_read(off_cap0 + 8'h0c);
    check("cap word 3", rd, w[127:96]);
    axi_write(off_cap0, 32'h0000_00f0, 4'h1);
    check("cap_valid", cap_valid, 1'b0);
  endtask : t_tag_clear
  task automatic t_malformed;
    logic [127:0] bad [3];
    bad[0] = mk(64'h100, 14'h0080, 12'h200, 1'b1, 1'b0, 5'h1f) | (128'h1 << 97);
    bad[1] = mk(64'h0, 14'h0007, 12'h007, 1'b0, 1'b0, 5'h1f);
    bad[2] = mk(64'h0, 14'h1000, 12'h000, 1'b0, 1'b0, 5'h1f);
    for (int i = 0; i < 3; i++)
    begin
      load_cap(bad[i], 1'b1);
      check("cap_valid", cap_valid, 1'b0);
    end
  endtask : t_malformed
  task automatic t_decode;
    // exponent code 48 gives exponent 4; the two cases take corrections -1 and +1
    load_cap(mk(64'h41230, 14'h2000, 12'h406, 1'b0, 1'b0, 5'h1f), 1'b1);
    check("cap_valid", cap_valid, 1'b1);
    check("base", base, 64'h20000);
    check("top", top, 65'h34000);
    axi_read(off_top0);
    check("top lo", rd, 32'h0003_4000);
    load_cap(mk(64'h78000, 14'h0100, 12'h406, 1'b0, 1'b0, 5'h1f), 1'b1);
    check("base", base, 64'h81000);
    check("top", top, 65'h94000);
  endtask : t_decode
  task automatic t_seal;
    int n;
    w = mk(64'h100, 14'h0080, 12'h200, 1'b1, 1'b1, 5'h1f);
    load_cap(w, 1'b1);
    access(64'h100, kind_read, 1'b0);
    n = jumps;
    axi_write(off_ctrl, {29'h0, cmd_jump}, 4'hf);
    check("jump count", jumps, n + 1);
    check("jump_cap", jcap, {w[127:92], 1'b0, w[90:0]});
    check("jump_tag", jtag, 1'b1);
    axi_write(off_ctrl, 32'h0000_0503, 4'hf);
    check("cap_valid", cap_valid, 1'b0);
    load_cap(mk(64'h100, 14'h0080, 12'h200, 1'b1, 1'b0, 5'h1f), 1'b1);
    axi_write(off_ctrl, {29'h0, cmd_link_seal}, 4'hf);
    axi_read(off_status);
    check("sealed", rd[2], 1'b1);
    access(64'h100, kind_read, 1'b0);
  endtask : t_seal
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_bounds();
    t_rights();
    t_tag_clear();
    t_malformed();
    t_decode();
    t_seal();
    report_and_stop();
  end
endmodule : tb
